/* phy_mode_control_regs.sv */
/*
 * Line-coding control and transceiver mode registers of a 10/100 PHY.
 * Assumes a management frame engine presents one-cycle register
 * read and write strobes with a register number, and feeds back the
 * negotiated mode; the datapath consumes the control outputs.
 */
`timescale 1ns/1ps
// Notes on behaviour
// - Bit 9 enables remote loopback, reset 0
// - Bit 8 enables DC restoration, reset 1
// - Bit 7 enables NRZI conversion, reset 1
// - Bit 6 enables 4B/5B coding, reset 1
// - Bit 5 isolates transmit and MII
// - Zero strap address sets transmit isolate
// - Bits 4-2 report mode, read only
// - Bit 1 bypasses MLT3, reset 0
// - Bit 0 disables scrambler, reset 0
// - Second register bit 11 lowers squelch
// - Bits 7-3 latch straps, then writable
// - Address goes MSB first on management
// - Zero strap address sets control isolate
// - Later zero address writes never isolate
// - Bit 1 accepts preamble-less frames, reset 1
// - Preamble accept mirrored in status bit 6
module phy_mode_control_regs (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Strap pins
   input wire logic [4:0] addr_strap,
   // Register access from the management engine
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [4:0] reg_num,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   output logic reg_rvalid,
   // Mode report from the negotiation logic
   input wire logic [2:0] op_mode_in,
   // Controls toward the datapath
   output logic remote_loopback_en,
   output logic dc_restore_en,
   output logic nrzi_conv_en,
   output logic block_code_en,
   output logic tx_isolate,
   output logic ternary_code_bypass,
   output logic scrambler_bypass,
   output logic long_reach_squelch,
   output logic [4:0] phy_addr_field,
   output logic phy_addr_msb,
   output logic preamble_skip_accept,
   output logic preamble_skip_status,
   output logic basic_isolate_set,
   output logic [2:0] op_mode_report
);
   strap_capture_if cap_if ();
   logic done_seen_ff;
   logic strap_pulse;
   logic wr_coding;
   logic wr_mode;
   logic [2:0] nxt_mode;

   strap_capture u_strap (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .addr_strap(addr_strap),
      .cap(cap_if.capture)
   );

   // One pulse when the strap value first becomes valid
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         done_seen_ff <= 1'b0;
      end else begin
         done_seen_ff <= cap_if.done;
      end
   end
   assign strap_pulse = cap_if.done && !done_seen_ff;
   assign wr_coding = reg_wr && (reg_num == phy_mode_pkg::FAST_LINE_CODING_REG);
   assign wr_mode = reg_wr && (reg_num == phy_mode_pkg::TRANSCEIVER_MODE_REG);

   // Line-coding control bits
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         remote_loopback_en <= phy_mode_pkg::RST_REMOTE_LOOPBACK;
         dc_restore_en <= phy_mode_pkg::RST_DC_RESTORE;
         nrzi_conv_en <= phy_mode_pkg::RST_NRZI_CONV;
         block_code_en <= phy_mode_pkg::RST_BLOCK_CODE;
         ternary_code_bypass <= phy_mode_pkg::RST_TERNARY_BYPASS;
         scrambler_bypass <= phy_mode_pkg::RST_SCRAMBLER_BYPASS;
      end else if (wr_coding) begin
         remote_loopback_en <= reg_wdata[phy_mode_pkg::REMOTE_LOOPBACK_BIT];
         dc_restore_en <= reg_wdata[phy_mode_pkg::DC_RESTORE_BIT];
         nrzi_conv_en <= reg_wdata[phy_mode_pkg::NRZI_CONV_BIT];
         block_code_en <= reg_wdata[phy_mode_pkg::BLOCK_CODE_BIT];
         ternary_code_bypass <= reg_wdata[phy_mode_pkg::TERNARY_BYPASS_BIT];
         scrambler_bypass <= reg_wdata[phy_mode_pkg::SCRAMBLER_BYPASS_BIT];
      end
   end

   // Transmit isolate: software write, or a zero strap address once
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_isolate <= phy_mode_pkg::RST_TX_ISOLATE;
      end else if (strap_pulse && cap_if.addr == phy_mode_pkg::ZERO_PHY_ADDR) begin
         tx_isolate <= 1'b1;
      end else if (wr_coding) begin
         tx_isolate <= reg_wdata[phy_mode_pkg::TX_ISOLATE_BIT];
      end
   end

   // Strap capture wins over a write landing in the same cycle
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         phy_addr_field <= phy_mode_pkg::RST_PHY_ADDR;
      end else if (strap_pulse) begin
         phy_addr_field <= cap_if.addr;
      end else if (wr_mode) begin
         phy_addr_field <= reg_wdata[phy_mode_pkg::PHY_ADDR_LSB +: 5];
      end
   end

   // Address bit 4 is the first on the wire
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         phy_addr_msb <= 1'b0;
      end else begin
         phy_addr_msb <= strap_pulse ? cap_if.addr[4] : (wr_mode ? reg_wdata[phy_mode_pkg::PHY_ADDR_LSB + 4] :
            phy_addr_field[4]);
      end
   end

   // Transceiver mode control bits
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         long_reach_squelch <= phy_mode_pkg::RST_LONG_REACH;
         preamble_skip_accept <= phy_mode_pkg::RST_PREAMBLE_SKIP;
         preamble_skip_status <= phy_mode_pkg::RST_PREAMBLE_SKIP;
      end else if (wr_mode) begin
         long_reach_squelch <= reg_wdata[phy_mode_pkg::LONG_REACH_BIT];
         preamble_skip_accept <= reg_wdata[phy_mode_pkg::PREAMBLE_SKIP_BIT];
         preamble_skip_status <= reg_wdata[phy_mode_pkg::PREAMBLE_SKIP_BIT];
      end
   end

   // Request to the basic control register; only the strap path raises it
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         basic_isolate_set <= 1'b0;
      end else begin
         basic_isolate_set <= strap_pulse && (cap_if.addr == phy_mode_pkg::ZERO_PHY_ADDR);
      end
   end

   // Mode report follows hardware only; unused codes fall back to negotiating
   always_comb begin
      unique case (op_mode_in)
         3'b011, 3'b100: nxt_mode = phy_mode_pkg::MODE_NEGOTIATING;
         default: nxt_mode = op_mode_in;
      endcase
   end
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         op_mode_report <= phy_mode_pkg::MODE_NEGOTIATING;
      end else begin
         op_mode_report <= nxt_mode;
      end
   end

   // Read data, one cycle after the strobe; reserved bits are zero
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 16'h0000;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         reg_rdata <= 16'h0000;
         if (reg_rd && reg_num == phy_mode_pkg::FAST_LINE_CODING_REG) begin
            reg_rdata[phy_mode_pkg::REMOTE_LOOPBACK_BIT] <= remote_loopback_en;
            reg_rdata[phy_mode_pkg::DC_RESTORE_BIT] <= dc_restore_en;
            reg_rdata[phy_mode_pkg::NRZI_CONV_BIT] <= nrzi_conv_en;
            reg_rdata[phy_mode_pkg::BLOCK_CODE_BIT] <= block_code_en;
            reg_rdata[phy_mode_pkg::TX_ISOLATE_BIT] <= tx_isolate;
            reg_rdata[phy_mode_pkg::OP_MODE_LSB +: 3] <= op_mode_report;
            reg_rdata[phy_mode_pkg::TERNARY_BYPASS_BIT] <= ternary_code_bypass;
            reg_rdata[phy_mode_pkg::SCRAMBLER_BYPASS_BIT] <= scrambler_bypass;
         end else if (reg_rd && reg_num == phy_mode_pkg::TRANSCEIVER_MODE_REG) begin
            reg_rdata[phy_mode_pkg::LONG_REACH_BIT] <= long_reach_squelch;
            reg_rdata[phy_mode_pkg::PHY_ADDR_LSB +: 5] <= phy_addr_field;
            reg_rdata[phy_mode_pkg::PREAMBLE_SKIP_BIT] <= preamble_skip_accept;
         end
      end
   end

   // Checks
   // Register numbers the bank answers; any other number reads as zero
   function automatic logic is_mapped(input logic [4:0] num);
      return (num == phy_mode_pkg::FAST_LINE_CODING_REG) || (num == phy_mode_pkg::TRANSCEIVER_MODE_REG);
   endfunction : is_mapped

   sequence zero_strap_s;
      strap_pulse && cap_if.addr == phy_mode_pkg::ZERO_PHY_ADDR;
   endsequence

   property isolate_follows_p;
      @(posedge mclk) disable iff (sys_rst) zero_strap_s |=> tx_isolate && basic_isolate_set;
   endproperty

   // Read strobes by target; each answer stands in the next cycle only
   sequence coding_rd_s;
      reg_rd && reg_num == phy_mode_pkg::FAST_LINE_CODING_REG;
   endsequence

   sequence mode_rd_s;
      reg_rd && reg_num == phy_mode_pkg::TRANSCEIVER_MODE_REG;
   endsequence

   sequence other_rd_s;
      reg_rd && !is_mapped(reg_num);
   endsequence

   // Strap update excluded: it may legally move the address and isolate bits
   sequence foreign_wr_s;
      reg_wr && !is_mapped(reg_num) && !strap_pulse;
   endsequence

   // Isolation comes from the strap once, afterwards only from writes
   strap_isolate_a: assert property (isolate_follows_p) else $error("zero strap did not isolate");
   basic_isolate_a: assert property (@(posedge mclk) disable iff (sys_rst)
      basic_isolate_set |-> $past(strap_pulse) && $past(cap_if.addr) == phy_mode_pkg::ZERO_PHY_ADDR)
      else $error("bad isolate request");
   isolate_pulse_a: assert property (@(posedge mclk) disable iff (sys_rst)
      basic_isolate_set |=> !basic_isolate_set) else $error("isolate request too long");
   no_write_iso_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (wr_mode && !strap_pulse) |=> !basic_isolate_set) else $error("address write isolated");
   isolate_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (!strap_pulse && !wr_coding) |=> $stable(tx_isolate)) else $error("isolate moved without a write");
   isolate_wr_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (wr_coding && !strap_pulse) |=> tx_isolate == $past(reg_wdata[phy_mode_pkg::TX_ISOLATE_BIT]))
      else $error("isolate not written");

   // Each writable bit takes its write data one cycle after the strobe
   loopback_wr_a: assert property (@(posedge mclk) disable iff (sys_rst)
      wr_coding |=> remote_loopback_en == $past(reg_wdata[phy_mode_pkg::REMOTE_LOOPBACK_BIT]))
      else $error("loopback not written");
   restore_wr_a: assert property (@(posedge mclk) disable iff (sys_rst)
      wr_coding |=> dc_restore_en == $past(reg_wdata[phy_mode_pkg::DC_RESTORE_BIT]))
      else $error("restore not written");
   coding_wr_a: assert property (@(posedge mclk) disable iff (sys_rst)
      wr_coding |=> nrzi_conv_en == $past(reg_wdata[phy_mode_pkg::NRZI_CONV_BIT]))
      else $error("conversion bit not written");
   block_wr_a: assert property (@(posedge mclk) disable iff (sys_rst)
      wr_coding |=> block_code_en == $past(reg_wdata[phy_mode_pkg::BLOCK_CODE_BIT]))
      else $error("block code bit not written");
   bypass_wr_a: assert property (@(posedge mclk) disable iff (sys_rst)
      wr_coding |=> ternary_code_bypass == $past(reg_wdata[phy_mode_pkg::TERNARY_BYPASS_BIT]))
      else $error("ternary bypass not written");
   scramble_wr_a: assert property (@(posedge mclk) disable iff (sys_rst)
      wr_coding |=> scrambler_bypass == $past(reg_wdata[phy_mode_pkg::SCRAMBLER_BYPASS_BIT]))
      else $error("scrambler bypass not written");
   squelch_wr_a: assert property (@(posedge mclk) disable iff (sys_rst)
      wr_mode |=> long_reach_squelch == $past(reg_wdata[phy_mode_pkg::LONG_REACH_BIT]))
      else $error("squelch bit not written");
   preamble_wr_a: assert property (@(posedge mclk) disable iff (sys_rst)
      wr_mode |=> preamble_skip_accept == $past(reg_wdata[phy_mode_pkg::PREAMBLE_SKIP_BIT]))
      else $error("preamble accept not written");
   addr_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (wr_mode && !strap_pulse) |=> phy_addr_field == $past(reg_wdata[phy_mode_pkg::PHY_ADDR_LSB +: 5]))
      else $error("address not written");
   addr_strap_a: assert property (@(posedge mclk) disable iff (sys_rst)
      strap_pulse |=> phy_addr_field == $past(cap_if.addr)) else $error("strap address not latched");
   msb_first_a: assert property (@(posedge mclk) disable iff (sys_rst)
      phy_addr_msb == phy_addr_field[4]) else $error("first address bit wrong");
   preamble_mirror_a: assert property (@(posedge mclk) disable iff (sys_rst)
      preamble_skip_status == preamble_skip_accept) else $error("preamble status mismatch");

   // Mode report follows the negotiation logic; software cannot touch it
   mode_track_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (op_mode_in != phy_mode_pkg::MODE_UNUSED_3 && op_mode_in != phy_mode_pkg::MODE_UNUSED_4)
      |=> op_mode_report == $past(op_mode_in)) else $error("mode report does not follow");
   mode_unused_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (op_mode_in == phy_mode_pkg::MODE_UNUSED_3 || op_mode_in == phy_mode_pkg::MODE_UNUSED_4)
      |=> op_mode_report == phy_mode_pkg::MODE_NEGOTIATING) else $error("unused mode not filtered");
   mode_legal_a: assert property (@(posedge mclk) disable iff (sys_rst)
      op_mode_report != phy_mode_pkg::MODE_UNUSED_3 && op_mode_report != phy_mode_pkg::MODE_UNUSED_4)
      else $error("unused mode reported");

   // Read answers: one valid cycle, zero in reserved and unmapped places
   rd_valid_a: assert property (@(posedge mclk) disable iff (sys_rst)
      reg_rd |=> reg_rvalid) else $error("read not answered");
   rd_idle_a: assert property (@(posedge mclk) disable iff (sys_rst)
      !reg_rd |=> !reg_rvalid && reg_rdata == 16'h0000) else $error("read data outside answer");
   read_zero_a: assert property (@(posedge mclk) disable iff (sys_rst)
      reg_rvalid |-> reg_rdata[15:12] == 4'h0 && reg_rdata[10] == 1'b0) else $error("reserved bits set");
   rd_coding_a: assert property (@(posedge mclk) disable iff (sys_rst)
      coding_rd_s |=> reg_rdata[phy_mode_pkg::OP_MODE_LSB +: 3] == $past(op_mode_report)
      && reg_rdata[phy_mode_pkg::TX_ISOLATE_BIT] == $past(tx_isolate)
      && (reg_rdata & 16'hfc00) == 16'h0000)
      else $error("line coding read wrong");
   rd_mode_a: assert property (@(posedge mclk) disable iff (sys_rst)
      mode_rd_s |=> reg_rdata[phy_mode_pkg::PHY_ADDR_LSB +: 5] == $past(phy_addr_field)
      && reg_rdata[phy_mode_pkg::PREAMBLE_SKIP_BIT] == $past(preamble_skip_accept)
      && (reg_rdata & 16'hf705) == 16'h0000)
      else $error("transceiver mode read wrong");
   rd_other_a: assert property (@(posedge mclk) disable iff (sys_rst)
      other_rd_s |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
   wr_ignore_a: assert property (@(posedge mclk) disable iff (sys_rst)
      foreign_wr_s |=> $stable({remote_loopback_en, dc_restore_en, nrzi_conv_en, block_code_en, tx_isolate,
      ternary_code_bypass, scrambler_bypass, long_reach_squelch, phy_addr_field, preamble_skip_accept}))
      else $error("unmapped write changed a register");
endmodule : phy_mode_control_regs

/* phy_mode_pkg.sv */
/*
 * Package for the line-coding and transceiver-mode register pair.
 * Assumes a management frame engine elsewhere decodes register numbers.
 */
package phy_mode_pkg;
   // Register numbers on the management interface
   localparam logic [4:0] BASIC_CONTROL_REG = 5'h00;
   localparam logic [4:0] BASIC_STATUS_REG = 5'h01;
   localparam logic [4:0] FAST_LINE_CODING_REG = 5'h13;
   localparam logic [4:0] TRANSCEIVER_MODE_REG = 5'h14;

   // Line-coding control field positions
   localparam int REMOTE_LOOPBACK_BIT = 9;
   localparam int DC_RESTORE_BIT = 8;
   localparam int NRZI_CONV_BIT = 7;
   localparam int BLOCK_CODE_BIT = 6;
   localparam int TX_ISOLATE_BIT = 5;
   localparam int OP_MODE_LSB = 2;
   localparam int TERNARY_BYPASS_BIT = 1;
   localparam int SCRAMBLER_BYPASS_BIT = 0;

   // Transceiver mode field positions
   localparam int LONG_REACH_BIT = 11;
   localparam int PHY_ADDR_LSB = 3;
   localparam int PREAMBLE_SKIP_BIT = 1;

   // Positions in the basic registers
   localparam int BASIC_ISOLATE_BIT = 10;
   localparam int PREAMBLE_STATUS_BIT = 6;

   // Reset values
   localparam logic RST_REMOTE_LOOPBACK = 1'b0;
   localparam logic RST_DC_RESTORE = 1'b1;
   localparam logic RST_NRZI_CONV = 1'b1;
   localparam logic RST_BLOCK_CODE = 1'b1;
   localparam logic RST_TX_ISOLATE = 1'b0;
   localparam logic RST_TERNARY_BYPASS = 1'b0;
   localparam logic RST_SCRAMBLER_BYPASS = 1'b0;
   localparam logic RST_LONG_REACH = 1'b0;
   localparam logic RST_PREAMBLE_SKIP = 1'b1;
   localparam logic [4:0] RST_PHY_ADDR = 5'h01;
   localparam logic [4:0] ZERO_PHY_ADDR = 5'h00;

   // Reported operating modes
   typedef enum logic [2:0] {
      MODE_NEGOTIATING = 3'b000,
      MODE_10_HALF = 3'b001,
      MODE_100_HALF = 3'b010,
      MODE_UNUSED_3 = 3'b011,
      MODE_UNUSED_4 = 3'b100,
      MODE_10_FULL = 3'b101,
      MODE_100_FULL = 3'b110,
      MODE_ISOLATED = 3'b111
   } op_mode_t;
endpackage : phy_mode_pkg

/* strap_capture_if.sv */
/*
 * Carrier between the strap capture module and the register bank.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface strap_capture_if;
   logic done;
   logic [4:0] addr;
   modport capture (output done, output addr);
   modport bank (input done, input addr);
endinterface : strap_capture_if

/* strap_capture.sv */
/*
 * Samples the address strap pins once after reset release.
 * Assumes the straps are steady around the release of sys_rst.
 */
`timescale 1ns/1ps
module strap_capture (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Strap pins
   input wire logic [4:0] addr_strap,
   // To the bank
   strap_capture_if.capture cap
);
   logic [4:0] sync1_ff;
   logic [4:0] sync2_ff;
   logic [4:0] sync3_ff;
   logic [1:0] cnt_ff;

   // Three-stage synchroniser; pins are asynchronous to mclk
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         sync1_ff <= 5'h00;
         sync2_ff <= 5'h00;
         sync3_ff <= 5'h00;
      end else begin
         sync1_ff <= addr_strap;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
      end
   end

   // Wait until the pipe is full and stages two and three agree
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_ff <= 2'h0;
         cap.done <= 1'b0;
         cap.addr <= 5'h00;
      end else if (!cap.done) begin
         if (cnt_ff != 2'h3) begin
            cnt_ff <= cnt_ff + 2'h1;
         end else if (sync2_ff == sync3_ff) begin
            cap.done <= 1'b1;
            cap.addr <= sync3_ff;
         end
      end
   end
endmodule : strap_capture

/* mgmt_station.sv */
/*
 * Station management model that issues register accesses to the bank.
 * Assumes every task is entered at a falling edge of mclk.
 */
`timescale 1ns/1ps
module mgmt_station (
   // Clock
   input wire logic mclk,
   // Requests toward the bank
   output logic reg_wr,
   output logic reg_rd,
   output logic [4:0] reg_num,
   output logic [15:0] reg_wdata,
   // Answers from the bank
   input wire logic [15:0] reg_rdata,
   input wire logic reg_rvalid
);
   // Idle state: the write bus carries a 5a5a filler pattern
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_num = 5'h00;
      reg_wdata = 16'h5a5a;
   end

   // One-cycle write strobe; the data bus is inverted once released
   task automatic wr(input logic [4:0] num, input logic [15:0] data);
      reg_wr = 1'b1;
      reg_num = num;
      reg_wdata = data;
      @(negedge mclk);
      reg_wr = 1'b0;
      reg_wdata = ~data;
   endtask : wr

   // Read after an optional idle gap; the answer is awaited a bounded time
   task automatic rd(input logic [4:0] num, input int gap, output logic [15:0] data, output bit ok);
      ok = 1'b0;
      data = 16'h0000;
      repeat (gap) @(negedge mclk);
      reg_rd = 1'b1;
      reg_num = num;
      for (int i = 0; i < 4 && !ok; i++) begin
         @(negedge mclk);
         reg_rd = 1'b0;
         if (reg_rvalid === 1'b1) begin
            ok = 1'b1;
            data = reg_rdata;
         end
      end
   endtask : rd
endmodule : mgmt_station

/* tb.sv */
/*
 * Self-checking bench for the line-coding and transceiver-mode registers.
 * Assumes the management model drives the access strobes at falling edges.
 */
`timescale 1ns/1ps
module tb;
   logic mclk;
   logic sys_rst;
   logic [4:0] addr_strap;
   logic [2:0] op_mode_in;
   logic reg_wr, reg_rd, reg_rvalid;
   logic [4:0] reg_num, phy_addr_field;
   logic [15:0] reg_wdata, reg_rdata, rdat;
   logic remote_loopback_en, dc_restore_en, nrzi_conv_en, block_code_en, tx_isolate;
   logic ternary_code_bypass, scrambler_bypass, long_reach_squelch, phy_addr_msb;
   logic preamble_skip_accept, preamble_skip_status, basic_isolate_set;
   logic [2:0] op_mode_report, exp_mode;
   logic [15:0] ctl, transceiver_mode_control;
   int failures, checks_done, pbase;
   // Only the counting process below assigns this; scenarios take a snapshot
   int pulses = 0;
   bit ok;

   mgmt_station u_sta (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_num(reg_num),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

   phy_mode_control_regs DUT (.mclk(mclk), .sys_rst(sys_rst), .addr_strap(addr_strap),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_num(reg_num), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .op_mode_in(op_mode_in),
      .remote_loopback_en(remote_loopback_en), .dc_restore_en(dc_restore_en),
      .nrzi_conv_en(nrzi_conv_en), .block_code_en(block_code_en), .tx_isolate(tx_isolate),
      .ternary_code_bypass(ternary_code_bypass), .scrambler_bypass(scrambler_bypass),
      .long_reach_squelch(long_reach_squelch), .phy_addr_field(phy_addr_field),
      .phy_addr_msb(phy_addr_msb), .preamble_skip_accept(preamble_skip_accept),
      .preamble_skip_status(preamble_skip_status), .basic_isolate_set(basic_isolate_set),
      .op_mode_report(op_mode_report));

   // Control outputs gathered per register so one compare covers each register's bits
   assign ctl = {9'h000, remote_loopback_en, dc_restore_en, nrzi_conv_en, block_code_en,
      tx_isolate, ternary_code_bypass, scrambler_bypass};
   assign transceiver_mode_control = {7'h00, long_reach_squelch, phy_addr_msb, phy_addr_field,
      preamble_skip_accept, preamble_skip_status};

   // Clock at 125 MHz
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // Counts isolate requests toward the basic control register
   always @(posedge mclk) begin
      if (basic_isolate_set === 1'b1) pulses <= pulses + 1;
   end

   task automatic complete_run;
      if (failures == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : complete_run

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Read with a bounded wait; a missing answer ends the run
   task automatic rchk(input logic [4:0] num, input logic [15:0] exp);
      u_sta.rd(num, 1, rdat, ok);
      if (!ok) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
         complete_run();
      end else begin
         chk(rdat, exp);
      end
   endtask : rchk

   // Main sequence
   initial begin
      failures = 0;
      checks_done = 0;
      pbase = 0;
      sys_rst = 1'b1;
      addr_strap = 5'h0a;
      op_mode_in = 3'b000;
      repeat (8) @(negedge mclk);
      sys_rst = 1'b0;
      repeat (8) @(negedge mclk);
      // Reset values and the latched strap address
      chk(ctl, 16'h0038);
      rchk(phy_mode_pkg::FAST_LINE_CODING_REG, 16'h01c0);
      rchk(phy_mode_pkg::TRANSCEIVER_MODE_REG, 16'h0052);
      // All ones: reserved and mode bits must not stick
      u_sta.wr(phy_mode_pkg::FAST_LINE_CODING_REG, 16'hffff);
      chk(ctl, 16'h007f);
      for (int m = 0; m < 8; m++) begin
         op_mode_in = m[2:0];
         exp_mode = (m == 3 || m == 4) ? 3'b000 : m[2:0];
         repeat (2) @(negedge mclk);
         chk({13'h0000, op_mode_report}, {13'h0000, exp_mode});
         rchk(phy_mode_pkg::FAST_LINE_CODING_REG, 16'h03e3 | {11'h000, exp_mode, 2'b00});
      end
      // Mixed pattern written, then read after one idle cycle
      u_sta.wr(phy_mode_pkg::FAST_LINE_CODING_REG, 16'h0203);
      chk(ctl, 16'h0043);
      rchk(phy_mode_pkg::FAST_LINE_CODING_REG, 16'h021f);
      // Second register: all ones, then all zeros
      u_sta.wr(phy_mode_pkg::TRANSCEIVER_MODE_REG, 16'hffff);
      chk(transceiver_mode_control, 16'h01ff);
      rchk(phy_mode_pkg::TRANSCEIVER_MODE_REG, 16'h08fa);
      pbase = pulses;
      u_sta.wr(phy_mode_pkg::TRANSCEIVER_MODE_REG, 16'h0000);
      repeat (3) @(negedge mclk);
      chk(transceiver_mode_control, 16'h0000);
      chk({14'h0000, tx_isolate, pulses != pbase}, 16'h0000);
      rchk(phy_mode_pkg::TRANSCEIVER_MODE_REG, 16'h0000);
      // Unmapped register: write ignored, read returns zero
      u_sta.wr(5'h1f, 16'hffff);
      rchk(5'h1f, 16'h0000);
      rchk(phy_mode_pkg::FAST_LINE_CODING_REG, 16'h021f);
      // Reset again with an all-zero strap address
      pbase = pulses;
      addr_strap = 5'h00;
      sys_rst = 1'b1;
      repeat (8) @(negedge mclk);
      sys_rst = 1'b0;
      repeat (10) @(negedge mclk);
      chk({10'h000, tx_isolate, phy_addr_field}, 16'h0020);
      chk(16'(pulses - pbase), 16'h0001);
      rchk(phy_mode_pkg::FAST_LINE_CODING_REG, 16'h01fc);
      complete_run();
   end
endmodule : tb
